//--- design/ubsp_defs.svh
// constants for the serial bridge: offsets, fields, reset values, timing
`ifndef UBSP_DEFS_SVH
`define UBSP_DEFS_SVH
`define UBSP_CLK_HZ 10000000
`define UBSP_BAUD_DEF 9600
`define UBSP_BAUD_MAX 921600
`define UBSP_DIV_DEF (`UBSP_CLK_HZ / `UBSP_BAUD_DEF)
`define UBSP_DIV_MAX ((`UBSP_CLK_HZ + `UBSP_BAUD_MAX / 2) / `UBSP_BAUD_MAX)
`define UBSP_OP_DATA 4'h1
`define UBSP_OP_FMT 4'h2
`define UBSP_OP_DIV 4'h3
`define UBSP_OP_FLOW 4'h4
`define UBSP_OP_CFGD 4'h5
`define UBSP_OP_STW 4'h6
`define UBSP_OP_LOCK 4'h7
`define UBSP_OP_DRD 4'h8
`define UBSP_OP_MODEM 4'h9
`define UBSP_OP_GPIO 4'ha
`define UBSP_OP_STAT 4'hb
`define UBSP_FMT_DEF 7'h03
`define UBSP_FLOW_NONE 2'h0
`define UBSP_FLOW_RTS 2'h1
`define UBSP_FLOW_DTR 2'h2
`define UBSP_FLOW_XON 2'h3
`define UBSP_XON 8'h11
`define UBSP_XOFF 8'h13
`define UBSP_VID_DEF 16'h0a0a
`define UBSP_PID_DEF 16'h0b0b
`define UBSP_ATTR_DEF 8'h80
`define UBSP_MAXP_DEF 8'h32
`define UBSP_REL_DEF 16'h0100
`define UBSP_SER_MAX 8'h3f
`define UBSP_PROD_MAX 8'h7e
`define UBSP_D_VID 8'h00
`define UBSP_D_PID 8'h02
`define UBSP_D_ATTR 8'h04
`define UBSP_D_MAXP 8'h05
`define UBSP_D_REL 8'h06
`define UBSP_D_SLEN 8'h08
`define UBSP_D_SER 8'h09
`define UBSP_D_PLEN 8'h48
`define UBSP_D_PROD 8'h49
`define UBSP_R_CMD 3'h0
`define UBSP_R_STAT 3'h1
`define UBSP_R_RSP 3'h2
`define UBSP_R_RXD 3'h3
`define UBSP_R_BUS 3'h4
`endif

//--- design/ubsp_dev.sv
// bridge device end: uart, sleep pins, gpio, descriptor store
// Operation
// - route usb data and serial commands
// - full-speed function link endpoint
// - suspend on bus suspend signaling
// - suspend drives sleep high, sleep_n low
// - sleep asserted after reset until configured
// - resume, bus reset, device reset exit suspend
// - exit suspend deasserts both sleep pins once configured
// - sleep pins released during device reset
// - modem lines are active low
// - rts/cts, dtr/dsr or xon/xoff flow
// - 5-8 bits, 1/1.5/2 stop, five parities
// - divider covers 300 to 921600 baud
// - top rate only with 7-8 bits
// - four gpio pins, each in or out
// - built-in descriptors when store unprogrammed
// - defaults 80h, 32h, release 0100h
// - serial max 63 default 0001; product 126
// - store written over the usb link
// - lock refuses further store writes
`timescale 1ns/100ps
`include "ubsp_defs.svh"
module ubsp_dev (
  ubsp_link_if.dev lnk,
  input wire logic hclk,
  input wire logic hresetn,
  output logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic dsr_n,
  output logic dtr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic slp_o,
  output logic slp_oe,
  output logic slp_n_o,
  output logic slp_n_oe,
  input wire logic [3:0] gpio_i,
  output logic [3:0] gpio_o,
  output logic [3:0] gpio_oe
);
  import ubsp_pkg::*;
  ubsp_dev_t r;
  ubsp_dev_t n;
  logic [7:0] store_mem [0:255];
  logic take;
  logic st_we;
  logic flow_ok;
  logic [15:0] half_m1;
  logic [2:0] nb_m1;
  logic par_on;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dflt(input logic [7:0] i);
    case (i)
      `UBSP_D_VID: dflt = 8'(`UBSP_VID_DEF >> 8);
      `UBSP_D_VID + 8'h01: dflt = 8'(`UBSP_VID_DEF & 16'h00ff);
      `UBSP_D_PID: dflt = 8'(`UBSP_PID_DEF >> 8);
      `UBSP_D_PID + 8'h01: dflt = 8'(`UBSP_PID_DEF & 16'h00ff);
      `UBSP_D_ATTR: dflt = `UBSP_ATTR_DEF;
      `UBSP_D_MAXP: dflt = `UBSP_MAXP_DEF;
      `UBSP_D_REL: dflt = 8'(`UBSP_REL_DEF >> 8);
      `UBSP_D_REL + 8'h01: dflt = 8'(`UBSP_REL_DEF & 16'h00ff);
      `UBSP_D_SLEN: dflt = 8'h04;
      `UBSP_D_SER, `UBSP_D_SER + 8'h01, `UBSP_D_SER + 8'h02: dflt = 8'h30;
      `UBSP_D_SER + 8'h03: dflt = 8'h31;
      `UBSP_D_PLEN: dflt = 8'h06;
      `UBSP_D_PROD: dflt = 8'h42;
      `UBSP_D_PROD + 8'h01: dflt = 8'h52;
      `UBSP_D_PROD + 8'h02: dflt = 8'h49;
      `UBSP_D_PROD + 8'h03: dflt = 8'h44;
      `UBSP_D_PROD + 8'h04: dflt = 8'h47;
      `UBSP_D_PROD + 8'h05: dflt = 8'h45;
      default: dflt = 8'h00;
    endcase
  endfunction : dflt

  function automatic logic cfg_bad(input logic [6:0] f, input logic [15:0] d);
    cfg_bad = (f[3:2] == 2'h3) || (f[3:2] == 2'h1 && f[1:0] != 2'h0) ||
              (f[6:4] > 3'h4) || (d < 16'(`UBSP_DIV_MAX)) ||
              (d == 16'(`UBSP_DIV_MAX) && f[1:0] < 2'h2);
  endfunction : cfg_bad

  ////////////////////////////////////////////////////////////////////
  assign take = lnk.cmd_valid && lnk.cmd_ready;
  assign st_we = take && lnk.cmd_op == `UBSP_OP_STW && !r.lock;
  assign lnk.cmd_ready = !(lnk.cmd_op == `UBSP_OP_DATA && r.txh_v);
  assign half_m1 = {1'b0, r.div[15:1]} - 16'h0001;
  assign nb_m1 = {1'b0, r.fmt[1:0]} + 3'h4;
  assign par_on = r.fmt[6:4] != 3'h0;
  assign rx_byte = r.rx_sh >> (2'h3 - r.fmt[1:0]);
  always_comb begin
    case (r.flow)
      `UBSP_FLOW_RTS: flow_ok = !cts_n;
      `UBSP_FLOW_DTR: flow_ok = !dsr_n;
      `UBSP_FLOW_XON: flow_ok = !r.xoff;
      default: flow_ok = 1'b1;
    endcase
  end

  always_ff @(posedge hclk) begin
    if (st_we) begin
      store_mem[lnk.cmd_addr] <= lnk.cmd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] m;
    logic px;
    logic ovr_ev;
    ovr_ev = 1'b0;
    m = 8'hff >> (2'h3 - r.fmt[1:0]);
    px = ^(r.txh_d & m);
    n = r;
    n.rsp_v = 1'b0;
    n.drv = 1'b1;
    if (r.tx_st != TX_IDLE) begin
      n.tx_cnt = (r.tx_cnt == 16'h0000) ? half_m1 : r.tx_cnt - 16'h0001;
    end
    case (r.tx_st)
      TX_IDLE: begin
        n.txd = 1'b1;
        if (r.txh_v && flow_ok) begin
          n.txh_v = 1'b0;
          n.tx_sh = r.txh_d;
          n.tx_st = TX_START;
          n.txd = 1'b0;
          n.tx_cnt = half_m1;
          n.tx_half = 3'h2;
          n.tx_bit = 3'h0;
          case (r.fmt[6:4])
            3'h1: n.tx_par = px;
            3'h2: n.tx_par = ~px;
            3'h3: n.tx_par = 1'b1;
            default: n.tx_par = 1'b0;
          endcase
        end
      end
      TX_START, TX_DATA, TX_PAR, TX_STOP: begin
        if (r.tx_cnt == 16'h0000) begin
          n.tx_half = r.tx_half - 3'h1;
          if (r.tx_half == 3'h1) begin
            n.tx_half = 3'h2;
            if (r.tx_st == TX_START) begin
              n.tx_st = TX_DATA;
              n.txd = r.tx_sh[0];
            end else if (r.tx_st == TX_DATA && r.tx_bit != nb_m1) begin
              n.tx_sh = r.tx_sh >> 1;
              n.txd = r.tx_sh[1];
              n.tx_bit = r.tx_bit + 3'h1;
            end else if (r.tx_st == TX_DATA && par_on) begin
              n.tx_st = TX_PAR;
              n.txd = r.tx_par;
            end else if (r.tx_st != TX_STOP) begin
              n.tx_st = TX_STOP;
              n.txd = 1'b1;
              n.tx_half = {1'b0, r.fmt[3:2]} + 3'h2;
            end else begin
              n.tx_st = TX_IDLE;
            end
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase

    if (r.rx_v && lnk.up_ready) begin
      n.rx_v = 1'b0;
    end
    if (r.rx_st != RX_IDLE) begin
      n.rx_cnt = (r.rx_cnt == 16'h0000) ? half_m1 : r.rx_cnt - 16'h0001;
    end
    case (r.rx_st)
      RX_IDLE: begin
        if (!rxd) begin
          n.rx_st = RX_START;
          n.rx_cnt = half_m1;
          n.rx_half = 3'h1;
        end
      end
      RX_START, RX_DATA, RX_PAR, RX_STOP: begin
        if (r.rx_cnt == 16'h0000) begin
          n.rx_half = r.rx_half - 3'h1;
          if (r.rx_half == 3'h1) begin
            n.rx_half = 3'h2;
            n.rx_bit = r.rx_bit + 3'h1;
            if (r.rx_st == RX_START) begin
              n.rx_st = rxd ? RX_IDLE : RX_DATA;
              n.rx_bit = 3'h0;
            end else if (r.rx_st == RX_DATA) begin
              n.rx_sh = {rxd, r.rx_sh[7:1]};
              if (r.rx_bit == nb_m1) begin
                n.rx_st = par_on ? RX_PAR : RX_STOP;
              end
            end else if (r.rx_st == RX_PAR) begin
              n.rx_st = RX_STOP;
            end else begin
              n.rx_st = RX_IDLE;
              if (r.flow == `UBSP_FLOW_XON && rx_byte == `UBSP_XOFF) begin
                n.xoff = 1'b1;
              end else if (r.flow == `UBSP_FLOW_XON && rx_byte == `UBSP_XON) begin
                n.xoff = 1'b0;
              end else if (r.rx_v && !lnk.up_ready) begin
                n.rx_ovr = 1'b1;
                ovr_ev = 1'b1;
              end else begin
                n.rx_v = 1'b1;
                n.rx_d = rx_byte;
              end
            end
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase

    if (lnk.bus_resume || lnk.bus_reset) begin
      n.susp = 1'b0;
    end else if (lnk.bus_suspend) begin
      n.susp = 1'b1;
    end

    if (take) begin
      n.rsp_v = lnk.cmd_op != `UBSP_OP_DATA;
      n.rsp_err = 1'b0;
      n.rsp_d = 8'h00;
      case (lnk.cmd_op)
        `UBSP_OP_DATA: begin
          n.txh_v = 1'b1;
          n.txh_d = lnk.cmd_data;
        end
        `UBSP_OP_FMT: begin
          n.rsp_err = cfg_bad(lnk.cmd_data[6:0], r.div);
          n.fmt = n.rsp_err ? r.fmt : lnk.cmd_data[6:0];
        end
        `UBSP_OP_DIV: begin
          n.rsp_err = cfg_bad(r.fmt, {lnk.cmd_addr, lnk.cmd_data});
          n.div = n.rsp_err ? r.div : {lnk.cmd_addr, lnk.cmd_data};
        end
        `UBSP_OP_FLOW: n.flow = lnk.cmd_data[1:0];
        `UBSP_OP_CFGD: n.configured = lnk.cmd_data[0];
        `UBSP_OP_STW: begin
          n.rsp_err = r.lock;
          n.prog = r.prog | !r.lock;
        end
        `UBSP_OP_LOCK: n.lock = 1'b1;
        `UBSP_OP_DRD: n.rsp_d = r.prog ? store_mem[lnk.cmd_addr] : dflt(lnk.cmd_addr);
        `UBSP_OP_MODEM: begin
          n.rts_m = lnk.cmd_data[0];
          n.dtr_m = lnk.cmd_data[1];
        end
        `UBSP_OP_GPIO: begin
          if (lnk.cmd_addr[0]) begin
            n.gout = lnk.cmd_data[3:0];
          end else begin
            n.gdir = lnk.cmd_data[3:0];
          end
        end
        `UBSP_OP_STAT: begin
          if (lnk.cmd_addr[0]) begin
            n.rsp_d = {dcd_n, ri_n, dsr_n, cts_n, gpio_i};
          end else begin
            n.rsp_d = {r.rx_ovr, r.lock, r.prog, r.configured, r.susp, r.xoff,
                       r.rx_v, r.txh_v};
            n.rx_ovr = ovr_ev;
          end
        end
        default: n.rsp_err = 1'b1;
      endcase
    end
    n.sleep = n.susp || !n.configured;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{tx_st: TX_IDLE, rx_st: RX_IDLE, fmt: `UBSP_FMT_DEF,
             div: 16'(`UBSP_DIV_DEF), txd: 1'b1, sleep: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign txd = r.txd;
  assign rts_n = (r.flow == `UBSP_FLOW_RTS) ? r.rx_v : !r.rts_m;
  assign dtr_n = (r.flow == `UBSP_FLOW_DTR) ? r.rx_v : !r.dtr_m;
  assign slp_o = r.sleep;
  assign slp_n_o = !r.sleep;
  assign slp_oe = r.drv;
  assign slp_n_oe = r.drv;
  assign gpio_o = r.gout;
  assign gpio_oe = r.gdir;
  assign lnk.rsp_valid = r.rsp_v;
  assign lnk.rsp_err = r.rsp_err;
  assign lnk.rsp_data = r.rsp_d;
  assign lnk.up_valid = r.rx_v;
  assign lnk.up_data = r.rx_d;
endmodule : ubsp_dev

//--- design/ubsp_host.sv
// usb host end: takes orders as an ahb-lite register slave
`timescale 1ns/100ps
`include "ubsp_defs.svh"
module ubsp_host (
  ubsp_link_if.host lnk,
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import ubsp_pkg::*;
  ubsp_host_t r;
  ubsp_host_t n;
  logic [2:0] idx;

  assign idx = haddr[4:2];

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.a_v = hsel && hready && htrans[1] && haddr[31:5] == 27'h0000000 && hsize == 3'h2;
    n.a_wr = hwrite;
    n.a_idx = idx;
    if (hsel && hready && htrans[1] && !hwrite) begin
      n.hrdata = 32'h00000000;
      if (n.a_v) begin
        case (idx)
          `UBSP_R_STAT: n.hrdata = {29'h0, r.up_v, r.rsp_v, r.pend};
          `UBSP_R_RSP: begin
            n.hrdata = {23'h0, r.rsp_e, r.rsp_d};
            n.rsp_v = 1'b0;
          end
          `UBSP_R_RXD: begin
            n.hrdata = {23'h0, r.up_v, r.up_d};
            n.up_v = 1'b0;
          end
          `UBSP_R_BUS: n.hrdata = {29'h0, r.bus};
          default: n.hrdata = 32'h00000000;
        endcase
      end
    end
    if (r.pend && lnk.cmd_ready) begin
      n.pend = 1'b0;
    end
    if (r.a_v && r.a_wr) begin
      if (r.a_idx == `UBSP_R_CMD && !r.pend) begin
        n.pend = 1'b1;
        n.op = hwdata[19:16];
        n.ad = hwdata[15:8];
        n.dt = hwdata[7:0];
      end else if (r.a_idx == `UBSP_R_BUS) begin
        n.bus = hwdata[2:0];
      end
    end
    if (lnk.rsp_valid) begin
      n.rsp_v = 1'b1;
      n.rsp_e = lnk.rsp_err;
      n.rsp_d = lnk.rsp_data;
    end
    if (lnk.up_valid && !r.up_v) begin
      n.up_v = 1'b1;
      n.up_d = lnk.up_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign lnk.cmd_valid = r.pend;
  assign lnk.cmd_op = r.op;
  assign lnk.cmd_addr = r.ad;
  assign lnk.cmd_data = r.dt;
  assign lnk.up_ready = !r.up_v;
  assign lnk.bus_suspend = r.bus[0];
  assign lnk.bus_resume = r.bus[1];
  assign lnk.bus_reset = r.bus[2];
endmodule : ubsp_host

//--- design/ubsp_link_if.sv
// link between the usb host end and the bridge device end
`timescale 1ns/100ps
interface ubsp_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [3:0] cmd_op;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  logic rsp_valid;
  logic rsp_err;
  logic [7:0] rsp_data;
  logic up_valid;
  logic up_ready;
  logic [7:0] up_data;
  logic bus_suspend;
  logic bus_resume;
  logic bus_reset;
  modport dev (
    input cmd_valid, cmd_op, cmd_addr, cmd_data, up_ready,
    input bus_suspend, bus_resume, bus_reset,
    output cmd_ready, rsp_valid, rsp_err, rsp_data, up_valid, up_data
  );
  modport host (
    output cmd_valid, cmd_op, cmd_addr, cmd_data, up_ready,
    output bus_suspend, bus_resume, bus_reset,
    input cmd_ready, rsp_valid, rsp_err, rsp_data, up_valid, up_data
  );
endinterface : ubsp_link_if

//--- design/ubsp_pkg.sv
// types shared by both ends of the serial bridge
package ubsp_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR = 5'b01000, TX_STOP = 5'b10000
  } ubsp_tx_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PAR = 5'b01000, RX_STOP = 5'b10000
  } ubsp_rx_t;
  typedef struct packed {
    ubsp_tx_t tx_st;
    ubsp_rx_t rx_st;
    logic [6:0] fmt;
    logic [15:0] div;
    logic [1:0] flow;
    logic xoff;
    logic txh_v;
    logic [7:0] txh_d;
    logic [7:0] tx_sh;
    logic [15:0] tx_cnt;
    logic [2:0] tx_half;
    logic [2:0] tx_bit;
    logic tx_par;
    logic txd;
    logic [7:0] rx_sh;
    logic [15:0] rx_cnt;
    logic [2:0] rx_half;
    logic [2:0] rx_bit;
    logic rx_v;
    logic [7:0] rx_d;
    logic rx_ovr;
    logic susp;
    logic configured;
    logic sleep;
    logic drv;
    logic rts_m;
    logic dtr_m;
    logic [3:0] gdir;
    logic [3:0] gout;
    logic prog;
    logic lock;
    logic rsp_v;
    logic rsp_err;
    logic [7:0] rsp_d;
  } ubsp_dev_t;
  typedef struct packed {
    logic a_v;
    logic a_wr;
    logic [2:0] a_idx;
    logic [31:0] hrdata;
    logic pend;
    logic [3:0] op;
    logic [7:0] ad;
    logic [7:0] dt;
    logic rsp_v;
    logic rsp_e;
    logic [7:0] rsp_d;
    logic up_v;
    logic [7:0] up_d;
    logic [2:0] bus;
  } ubsp_host_t;
endpackage : ubsp_pkg

//--- verif/tb.sv
// self-checking bench for both ends of the serial bridge
`timescale 1ns/100ps
`include "ubsp_defs.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic txd, cts_n, rts_n, dsr_n, dtr_n, dcd_n, ri_n;
  logic slp_o, slp_oe, slp_n_o, slp_n_oe;
  logic [3:0] gpio_i, gpio_o, gpio_oe;
  logic [15:0] desc_tab [8] = '{16'h0480, 16'h0532, 16'h0601, 16'h0700,
    16'h0804, 16'h0930, 16'h0c31, 16'h4806};
  int miscompares;
  int compares;
  ubsp_link_if ubsp_link_if_inst ();
  ubsp_dev ubsp_dev_inst (.lnk(ubsp_link_if_inst), .hclk(hclk), .hresetn(hresetn),
    .txd(txd), .rxd(txd), .cts_n(cts_n), .rts_n(rts_n), .dsr_n(dsr_n), .dtr_n(dtr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .slp_o(slp_o), .slp_oe(slp_oe), .slp_n_o(slp_n_o),
    .slp_n_oe(slp_n_oe), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe));
  ubsp_host ubsp_host_inst (.lnk(ubsp_link_if_inst), .hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
  ubsp_props ubsp_props_inst (.hclk(hclk), .hresetn(hresetn), .txd(txd), .rts_n(rts_n),
    .cmd_valid(ubsp_link_if_inst.cmd_valid), .cmd_ready(ubsp_link_if_inst.cmd_ready),
    .cmd_op(ubsp_link_if_inst.cmd_op), .cmd_data(ubsp_link_if_inst.cmd_data),
    .rsp_valid(ubsp_link_if_inst.rsp_valid), .rsp_err(ubsp_link_if_inst.rsp_err),
    .bus_suspend(ubsp_link_if_inst.bus_suspend), .bus_resume(ubsp_link_if_inst.bus_resume),
    .bus_reset(ubsp_link_if_inst.bus_reset), .slp_o(slp_o), .slp_n_o(slp_n_o),
    .slp_oe(slp_oe), .slp_n_oe(slp_n_oe));
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic stuck;
    miscompares++;
    test_done();
  endtask : stuck
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask : tick
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) stuck();
  endtask : rdy
  // one single word transfer; read data left in q
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : ahb
  // order over the link, then poll for its answer
  task automatic cmd(input logic [3:0] op, input logic [7:0] ad, input logic [7:0] dt);
    int n;
    ahb(1'b1, 32'h0, {12'h0, op, ad, dt});
    n = 0;
    do begin
      ahb(1'b0, 32'h4, 32'h0);
      n++;
    end while ((q[0] || !q[1]) && n < 20);
    if (q[0] !== 1'b0 || q[1] !== 1'b1) stuck();
    ahb(1'b0, 32'h8, 32'h0);
  endtask : cmd
  task automatic fall;
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 80) begin
      @(posedge hclk);
      n++;
    end
    if (txd !== 1'b0) stuck();
  endtask : fall
  //////////////////////////////////////////////////////////////////////
  task automatic t_sleep;
    check({slp_o, slp_n_o, slp_oe, slp_n_oe}, 4'b1011);
    cmd(`UBSP_OP_CFGD, 8'h00, 8'h01);
    tick(2);
    check(slp_o, 1'b0);
    ahb(1'b1, 32'h10, 32'h1);
    tick(3);
    check({slp_o, slp_n_o}, 2'b10);
    ahb(1'b1, 32'h10, 32'h2);
    tick(3);
    check({slp_o, slp_n_o}, 2'b01);
    ahb(1'b1, 32'h10, 32'h1);
    tick(3);
    ahb(1'b1, 32'h10, 32'h4);
    tick(3);
    check({slp_o, slp_n_o}, 2'b01);
    ahb(1'b1, 32'h10, 32'h1);
    tick(3);
    hresetn <= 1'b0;
    tick(2);
    check({slp_oe, slp_n_oe}, 2'b00);
    hresetn <= 1'b1;
    tick(3);
    check({slp_o, slp_oe}, 2'b11);
    cmd(`UBSP_OP_CFGD, 8'h00, 8'h01);
    tick(2);
    check(slp_o, 1'b0);
    $display("sleep test ended");
  endtask : t_sleep
  task automatic t_desc;
    foreach (desc_tab[i]) begin
      cmd(`UBSP_OP_DRD, desc_tab[i][15:8], 8'h00);
      check(q[8:0], {1'b0, desc_tab[i][7:0]});
    end
    $display("descriptor test ended");
  endtask : t_desc
  task automatic t_store;
    cmd(`UBSP_OP_STW, 8'h04, 8'h55);
    check(q[8], 1'b0);
    check(hresp, 1'b0);
    cmd(`UBSP_OP_DRD, 8'h04, 8'h00);
    check(q[8:0], 9'h055);
    cmd(`UBSP_OP_LOCK, 8'h00, 8'h00);
    cmd(`UBSP_OP_STW, 8'h04, 8'haa);
    check(q[8], 1'b1);
    cmd(`UBSP_OP_DRD, 8'h04, 8'h00);
    check(q[8:0], 9'h055);
    $display("store test ended");
  endtask : t_store
  task automatic t_fmt;
    for (int p = 0; p < 5; p++) begin
      cmd(`UBSP_OP_FMT, 8'h00, {1'b0, p[2:0], 4'h3});
      check(q[8], 1'b0);
    end
    cmd(`UBSP_OP_FMT, 8'h00, 8'h07);
    check(q[8], 1'b1);
    cmd(`UBSP_OP_FMT, 8'h00, 8'h0f);
    check(q[8], 1'b1);
    cmd(`UBSP_OP_FMT, 8'h00, 8'h04);
    check(q[8], 1'b0);
    cmd(`UBSP_OP_DIV, 8'h00, 8'h0b);
    check(q[8], 1'b1);
    cmd(`UBSP_OP_FMT, 8'h00, 8'h02);
    cmd(`UBSP_OP_DIV, 8'h00, 8'h0b);
    check(q[8], 1'b0);
    cmd(`UBSP_OP_DIV, 8'h82, 8'h35);
    check(q[8], 1'b0);
    cmd(`UBSP_OP_DIV, 8'h00, 8'h10);
    $display("format test ended");
  endtask : t_fmt
  // one character out on the wire, back in through the loop
  task automatic t_frame(input logic [7:0] f, input logic [7:0] b, input logic [10:0] ex,
    input int nb);
    cmd(`UBSP_OP_FMT, 8'h00, f);
    ahb(1'b1, 32'h0, {12'h0, `UBSP_OP_DATA, 8'h00, b});
    fall();
    tick(7);
    for (int i = 0; i < nb; i++) begin
      check(txd, ex[i]);
      tick(16);
    end
    tick(20);
    ahb(1'b0, 32'hc, 32'h0);
    check(q[8:0], {1'b1, b});
    $display("frame test ended");
  endtask : t_frame
  task automatic t_flow;
    int lows;
    for (int m = 1; m < 3; m++) begin
      lows = 0;
      cmd(`UBSP_OP_FLOW, 8'h00, {6'h0, m[1:0]});
      {dsr_n, cts_n} <= 2'b11;
      ahb(1'b1, 32'h0, {12'h0, `UBSP_OP_DATA, 8'h00, 8'h5a});
      repeat (40) begin
        @(posedge hclk);
        lows += (txd !== 1'b1);
      end
      check(lows[15:0], 16'h0);
      ahb(1'b1, 32'h0, {12'h0, `UBSP_OP_DATA, 8'h00, 8'ha5});
      tick(4);
      ahb(1'b0, 32'h4, 32'h0);
      check(q[2:0], 3'h1);
      {dsr_n, cts_n} <= 2'b00;
      fall();
      tick(200);
      ahb(1'b0, 32'hc, 32'h0);
      check(q[8:0], 9'h15a);
      tick(180);
      ahb(1'b0, 32'hc, 32'h0);
      check(q[8:0], 9'h1a5);
    end
    {dsr_n, cts_n} <= 2'b01;
    cmd(`UBSP_OP_FLOW, 8'h00, {6'h0, `UBSP_FLOW_XON});
    ahb(1'b1, 32'h0, {12'h0, `UBSP_OP_DATA, 8'h00, `UBSP_XOFF});
    tick(200);
    cmd(`UBSP_OP_STAT, 8'h00, 8'h00);
    check(q[2], 1'b1);
    ahb(1'b0, 32'hc, 32'h0);
    check(q[8], 1'b0);
    cmd(`UBSP_OP_FLOW, 8'h00, {6'h0, `UBSP_FLOW_NONE});
    $display("flow test ended");
  endtask : t_flow
  task automatic t_pins;
    cmd(`UBSP_OP_GPIO, 8'h00, 8'h05);
    cmd(`UBSP_OP_GPIO, 8'h01, 8'h03);
    tick(2);
    check({gpio_oe, gpio_o}, 8'h53);
    cmd(`UBSP_OP_STAT, 8'h01, 8'h00);
    check(q[7:0], 8'h59);
    cmd(`UBSP_OP_MODEM, 8'h00, 8'h01);
    tick(2);
    check({rts_n, dtr_n}, 2'b01);
    cmd(`UBSP_OP_MODEM, 8'h00, 8'h02);
    tick(2);
    check({rts_n, dtr_n}, 2'b10);
    $display("pin test ended");
  endtask : t_pins
  //////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {dcd_n, ri_n, dsr_n, cts_n, gpio_i} = 8'h59;
    miscompares = 0;
    compares = 0;
    tick(3);
    check({slp_oe, slp_n_oe, txd}, 3'b001);
    hresetn <= 1'b1;
    tick(2);
    t_sleep();
    t_desc();
    t_store();
    t_fmt();
    t_frame(8'h03, 8'ha5, 11'h34a, 10);
    t_frame(8'h0b, 8'ha5, 11'h74a, 11);
    t_frame(8'h13, 8'h07, 11'h60e, 11);
    t_frame(8'h23, 8'h07, 11'h40e, 11);
    t_frame(8'h33, 8'h07, 11'h60e, 11);
    t_frame(8'h43, 8'h07, 11'h40e, 11);
    t_flow();
    t_pins();
    test_done();
  end
endmodule : tb

//--- verif/ubsp_props.sv
// concurrent checks on the link between both ends
`timescale 1ns/100ps
`include "ubsp_defs.svh"
module ubsp_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic bus_suspend,
  input wire logic bus_resume,
  input wire logic bus_reset,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic slp_o,
  input wire logic slp_n_o,
  input wire logic slp_oe,
  input wire logic slp_n_oe
);
  logic tk;
  logic cfg_reg;
  logic lk_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign tk = cmd_valid && cmd_ready;
  //////////////////////////////////////////////////////////////////////
  // last configure order and lock seen on the link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= 1'b0;
      lk_reg <= 1'b0;
    end else if (tk) begin
      if (cmd_op == `UBSP_OP_CFGD) cfg_reg <= cmd_data[0];
      if (cmd_op == `UBSP_OP_LOCK) lk_reg <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_rsp;
    tk && cmd_op != `UBSP_OP_DATA |=> rsp_valid ##1 !rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no single response pulse");
  property p_data;
    tk && cmd_op == `UBSP_OP_DATA |=> !rsp_valid;
  endproperty
  a_data: assert property (p_data) else $error("response to data byte");
  property p_susp;
    bus_suspend && !bus_resume && !bus_reset |-> ##[1:2] slp_o;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not shown");
  property p_pair;
    slp_n_o != slp_o;
  endproperty
  a_pair: assert property (p_pair) else $error("sleep pins disagree");
  property p_cfg;
    !cfg_reg |-> slp_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("awake before configured");
  property p_exit;
    cfg_reg && (bus_resume || bus_reset) |-> ##[1:2] !slp_o;
  endproperty
  a_exit: assert property (p_exit) else $error("suspend not left");
  property p_float;
    $rose(hresetn) |-> !slp_oe && !slp_n_oe;
  endproperty
  a_float: assert property (p_float) else $error("sleep pins driven in reset");
  property p_start;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_rts;
    tk && cmd_op == `UBSP_OP_MODEM |-> ##2 rts_n == !$past(cmd_data[0], 2);
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_lock;
    tk && lk_reg && cmd_op == `UBSP_OP_STW |=> rsp_valid && rsp_err;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted");
endmodule : ubsp_props
